/* File: hw/countdown.sv */
`timescale 1ns/1ps
module countdown
  import timer_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // control and status
  count_if.cnt      cif
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        exp;
  } cd_state_t;

  cd_state_t st_q;
  cd_state_t st_d;

  // one evaluation per tick; software load takes precedence
  always_comb begin
    st_d     = st_q;
    st_d.exp = 1'b0;
    if (cif.load) begin
      st_d.cnt = cif.load_val;
    end else if (cif.enable) begin
      if (st_q.cnt == RST_WORD) begin
        st_d.exp = 1'b1;
        if (cif.reload_on) begin
          st_d.cnt = cif.reload_val;
        end
      end else begin
        st_d.cnt = st_q.cnt - DEC_STEP;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cif.count   = st_q.cnt;
  assign cif.expired = st_q.exp;

endmodule

/* File: hw/io_decode.sv */
`timescale 1ns/1ps
module io_decode
  import timer_pkg::*;
(
  // io request
  input  wire logic [11:0] addr,
  input  wire logic        wr_en,
  // decoded write strobes
  output logic             wr_interval,
  output logic             wr_tick_cnt,
  output logic             wr_tick_on,
  output logic             wr_os_cnt,
  output logic             wr_os_on
);

  // time aliases have no strobe, so writes there fall away
  always_comb begin
    wr_interval = 1'b0;
    wr_tick_cnt = 1'b0;
    wr_tick_on  = 1'b0;
    wr_os_cnt   = 1'b0;
    wr_os_on    = 1'b0;
    if (wr_en && addr == OFS_TICK_INTERVAL) begin
      wr_interval = 1'b1;
    end else if (wr_en && addr == OFS_TICK_COUNT) begin
      wr_tick_cnt = 1'b1;
    end else if (wr_en && addr == OFS_TICK_ON) begin
      wr_tick_on = 1'b1;
    end else if (wr_en && addr == OFS_ONESHOT_COUNT) begin
      wr_os_cnt = 1'b1;
    end else if (wr_en && addr == OFS_ONESHOT_ON) begin
      wr_os_on = 1'b1;
    end
  end

endmodule

/* File: hw/timer_unit.sv */
// What this block does
// - 32-bit writable register holds periodic interval minus one.
// - enabled nonzero periodic countdown drops by one each tick.
// - enable bit 0 gates periodic timer; off means hold, no interrupt.
// - enabled countdown at zero pulses line 0 and reloads the interval.
// - each timer evaluated per tick; line low unless expiry seen.
// - system time low and high words readable, writes ignored.
// - second one-shot timer runs independently of the periodic one.
// - one-shot 32-bit writable countdown drops by one while enabled.
// - one-shot enable bit 0 gates it; off freezes, no interrupt.
// - one-shot expiry appears on line 1, not line 0.
// - one-shot never reloads; at zero it raises line 1 each tick.
// - one-shot expiry only raises interrupt, never resets the core.
`timescale 1ns/1ps
module timer_unit
  import timer_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // io register bus
  input  wire logic [11:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [31:0] io_wdata,
  output logic      [31:0] io_rdata,
  // system time counter
  input  wire logic [63:0] sys_time,
  // interrupt lines
  output logic             irq_tick,
  output logic             irq_oneshot
);

  // ***************************************************
  // register state
  // ***************************************************
  typedef struct packed {
    logic [31:0] interval;
    logic        tick_on;
    logic        os_on;
    logic [31:0] rdata;
  } top_state_t;

  top_state_t st_q;
  top_state_t st_d;

  logic wr_interval;
  logic wr_tick_cnt;
  logic wr_tick_on;
  logic wr_os_cnt;
  logic wr_os_on;

  count_if tick_if ();
  count_if os_if ();

  // ***************************************************
  // address decode
  // ***************************************************
  io_decode u_dec (
    .addr        (io_addr),
    .wr_en       (io_wr),
    .wr_interval (wr_interval),
    .wr_tick_cnt (wr_tick_cnt),
    .wr_tick_on  (wr_tick_on),
    .wr_os_cnt   (wr_os_cnt),
    .wr_os_on    (wr_os_on)
  );

  // ***************************************************
  // countdowns
  // ***************************************************
  // periodic: reloads on expiry
  assign tick_if.load       = wr_tick_cnt;
  assign tick_if.load_val   = io_wdata;
  assign tick_if.enable     = st_q.tick_on;
  assign tick_if.reload_on  = 1'b1;
  assign tick_if.reload_val = st_q.interval;

  // one-shot: separate instance, no reload, stays at zero
  assign os_if.load       = wr_os_cnt;
  assign os_if.load_val   = io_wdata;
  assign os_if.enable     = st_q.os_on;
  assign os_if.reload_on  = 1'b0;
  assign os_if.reload_val = RST_WORD;

  countdown u_tick (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .cif      (tick_if)
  );

  countdown u_oneshot (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .cif      (os_if)
  );

  // ***************************************************
  // register writes and reads
  // ***************************************************
  // read data registered so the output comes from a flop
  always_comb begin
    st_d = st_q;
    if (wr_interval) begin
      st_d.interval = io_wdata;
    end
    if (wr_tick_on) begin
      st_d.tick_on = io_wdata[ENABLE_BIT];
    end
    if (wr_os_on) begin
      st_d.os_on = io_wdata[ENABLE_BIT];
    end
    st_d.rdata = RST_WORD;
    if (io_rd) begin
      if (io_addr == OFS_TICK_INTERVAL) begin
        st_d.rdata = st_q.interval;
      end else if (io_addr == OFS_TICK_COUNT) begin
        st_d.rdata = tick_if.count;
      end else if (io_addr == OFS_TICK_ON) begin
        st_d.rdata = {31'h0000_0000, st_q.tick_on};
      end else if (io_addr == OFS_SYS_LO) begin
        st_d.rdata = sys_time[31:0];
      end else if (io_addr == OFS_SYS_HI) begin
        st_d.rdata = sys_time[63:32];
      end else if (io_addr == OFS_ONESHOT_COUNT) begin
        st_d.rdata = os_if.count;
      end else if (io_addr == OFS_ONESHOT_ON) begin
        st_d.rdata = {31'h0000_0000, st_q.os_on};
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************
  // expiry flags are flops inside each countdown; only an interrupt,
  // nothing here drives any reset back into the core
  assign irq_tick    = tick_if.expired;
  assign irq_oneshot = os_if.expired;
  assign io_rdata    = st_q.rdata;

endmodule

/* File: include/count_if.sv */
`timescale 1ns/1ps
// load and status path between the top and one countdown
interface count_if;
  logic        load;
  logic [31:0] load_val;
  logic        enable;
  logic        reload_on;
  logic [31:0] reload_val;
  logic [31:0] count;
  logic        expired;

  modport ctl (output load, load_val, enable, reload_on, reload_val,
               input count, expired);
  modport cnt (input load, load_val, enable, reload_on, reload_val,
               output count, expired);
endinterface

/* File: include/timer_pkg.sv */
package timer_pkg;

  // ***************************************************
  // register map (byte addresses on the io bus)
  // ***************************************************
  localparam logic [11:0] OFS_TICK_INTERVAL = 12'h020;
  localparam logic [11:0] OFS_TICK_COUNT    = 12'h024;
  localparam logic [11:0] OFS_TICK_ON       = 12'h028;
  localparam logic [11:0] OFS_SYS_LO        = 12'h02C;
  localparam logic [11:0] OFS_SYS_HI        = 12'h030;
  localparam logic [11:0] OFS_ONESHOT_COUNT = 12'h034;
  localparam logic [11:0] OFS_ONESHOT_ON    = 12'h038;

  // ***************************************************
  // field layout and reset values
  // ***************************************************
  localparam int          ENABLE_BIT    = 0;
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  localparam logic [31:0] DEC_STEP      = 32'h0000_0001;

endpackage

/* File: verification/sys_time_src.sv */
`timescale 1ns/1ps
module sys_time_src
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // running time seen by the aliases
  output logic      [63:0] sys_time
);
  // starts near a low word wrap so the high alias moves too
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sys_time <= 64'h0000_0007_FFFF_FFF0;
    end else begin
      sys_time <= sys_time + 64'h1;
    end
  end
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench
  import timer_pkg::*;
;
  logic core_clk, sys_rst, io_wr, io_rd, irq_tick, irq_oneshot, t, o;
  logic [11:0] io_addr;
  logic [31:0] io_wdata, io_rdata, r, e;
  logic [63:0] sys_time;
  int err_total, tests_run, cyc, seed;
  int unsigned m [16]; // model words, index is address bits 5:2
  timer_unit dut (.*);
  sys_time_src src (.*);
  always #12.5 core_clk = ~core_clk;
  // model uses the state before each edge, then applies the write
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      m = '{default: 0};
      {t, o, e} = '0;
    end else begin
      {m[12], m[11]} = sys_time;
      e = io_rd && io_addr inside {[32:56]} ? m[io_addr[5:2]] : 0;
      t = m[10] && m[9] == 0;
      if (m[10]) m[9] = m[9] == 0 ? m[8] : m[9] - 1;
      o = m[14] && m[13] == 0;
      if (m[14] && m[13] != 0) m[13]--;
      if (io_wr && io_addr inside {[32:40], 52, 56})
        m[io_addr[5:2]] = io_addr[3:2] == 2 ? io_wdata[0] : io_wdata;
      t &= !(io_wr && io_addr == OFS_TICK_COUNT);
      o &= !(io_wr && io_addr == OFS_ONESHOT_COUNT);
    end
  end
  task automatic chk(string nm, logic [31:0] got, want);
    tests_run++;
    if (got !== want) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, want, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // compare every cycle out of reset; a hang counts as a mismatch
  always @(negedge core_clk) begin
    if (!sys_rst) begin
      chk("io_rdata", io_rdata, e);
      chk("irq_tick", irq_tick, t);
      chk("irq_oneshot", irq_oneshot, o);
    end
    cyc++;
    if (cyc > 1000) begin
      err_total++;
      end_sim();
    end
  end
  // one access, then n idle cycles
  task automatic acc(bit w, logic [11:0] a, logic [31:0] d, int n = 0);
    @(negedge core_clk);
    {io_wr, io_rd, io_addr, io_wdata} <= {w, !w, a, d};
    repeat (n) begin
      @(negedge core_clk);
      {io_wr, io_rd} <= 2'b00;
    end
  endtask
  initial begin
    {core_clk, io_wr, io_rd, io_addr, io_wdata, err_total, tests_run} = '0;
    cyc = 0;
    seed = 32'h4154260C;
    sys_rst = 1'b1;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    acc(1, OFS_SYS_LO, $random(seed));
    for (int a = 32; a <= 60; a += 4) acc(0, 12'(a), 0, a / 60);
    $display("test map done");
    acc(1, OFS_TICK_INTERVAL, 3);
    acc(1, OFS_TICK_COUNT, 2);
    acc(1, OFS_TICK_ON, 1, 12);
    acc(1, OFS_TICK_ON, 32'hFFFF_FFFE, 4);
    acc(0, OFS_TICK_COUNT, 0, 1);
    $display("test periodic done");
    acc(1, OFS_TICK_INTERVAL, 0);
    acc(1, OFS_TICK_ON, 1);
    acc(1, OFS_ONESHOT_COUNT, 3);
    acc(1, OFS_ONESHOT_ON, 1, 8);
    acc(1, OFS_ONESHOT_COUNT, 2, 5);
    acc(1, OFS_ONESHOT_ON, 0);
    acc(0, OFS_ONESHOT_COUNT, 0, 2);
    $display("test oneshot done");
    repeat (80) begin
      r = $random(seed);
      acc(r[4], 12'h020 + {7'h0, r[2:0], 2'h0}, {28'h0, r[31:28]});
    end
    acc(0, OFS_TICK_ON, 0, 3);
    $display("test random done");
    // mid-run reset must clear counts and enables in design and model alike
    sys_rst = 1'b1;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    acc(0, OFS_TICK_COUNT, 0);
    acc(0, OFS_ONESHOT_ON, 0, 2);
    $display("test reset done");
    end_sim();
  end
endmodule

/* File: verification/timer_unit_assertions.sv */
`timescale 1ns/1ps
module timer_unit_assertions
  import timer_pkg::*;
(
  // watched top ports
  input wire logic core_clk, sys_rst, io_wr, io_rd, irq_tick, irq_oneshot,
  input wire logic [11:0] io_addr,
  input wire logic [31:0] io_wdata, io_rdata,
  input wire logic [63:0] sys_time
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  chk_lo_read: assert property (io_rd && io_addr == OFS_SYS_LO
    |=> io_rdata == $past(sys_time[31:0])) else $error("lo alias");
  chk_hi_read: assert property (io_rd && io_addr == OFS_SYS_HI
    |=> io_rdata == $past(sys_time[63:32])) else $error("hi alias");
  chk_on_read: assert property (io_rd && io_addr[3:0] == 4'h8
    |=> io_rdata[31:1] == 31'h0) else $error("enable width");
  // a count write beats expiry in its own cycle
  chk_tick_wclr: assert property (io_wr && io_addr == OFS_TICK_COUNT
    |=> !irq_tick) else $error("line 0 after write");
  chk_os_wclr: assert property (io_wr && io_addr == OFS_ONESHOT_COUNT
    |=> !irq_oneshot) else $error("line 1 after write");
  // the old enable still rules the write edge
  chk_tick_off: assert property (io_wr && io_addr == OFS_TICK_ON
    && !io_wdata[0] |-> ##2 !irq_tick) else $error("line 0 while off");
  chk_os_off: assert property (io_wr && io_addr == OFS_ONESHOT_ON
    && !io_wdata[0] |-> ##2 !irq_oneshot) else $error("line 1 while off");
  chk_os_hold: assert property (irq_oneshot && !io_wr && !$past(io_wr)
    |=> irq_oneshot) else $error("line 1 dropped");
  cov_tick: cover property (irq_tick);
  cov_os: cover property (irq_oneshot ##1 irq_oneshot);
  cov_hi: cover property (io_rd && io_addr == OFS_SYS_HI);
endmodule
bind timer_unit timer_unit_assertions chk (.*);
